// ---- pkg/ccp_pkg.sv ----
// Package: constants and types of the camera command and control port
package ccp_pkg;

	localparam logic [6:0]  SLAVE_ADDR        = 7'h2A;
	localparam int          WORD_W            = 16;
	localparam int          PARAM_N           = 32;
	localparam int          IDX_W             = 5;
	localparam int          SYNC_STAGES       = 3;

	// Command kinds, carried in bits 1:0 of the command word
	localparam logic [1:0]  CMD_GET           = 2'h0;
	localparam logic [1:0]  CMD_SET           = 2'h1;
	localparam logic [1:0]  CMD_RUN           = 2'h2;
	localparam logic [1:0]  CMD_BAD           = 2'h3;
	localparam int          CMD_IDX_LSB       = 2;

	// Run function codes (parameter index field of a run command)
	localparam logic [4:0]  RUN_SAVE_DEFAULTS = 5'h01;
	localparam logic [4:0]  RUN_LOAD_DEFAULTS = 5'h02;

	// Parameter indices
	localparam logic [4:0]  P_AGC_MODE        = 5'h00;
	localparam logic [4:0]  P_AGC_ROI0        = 5'h01;
	localparam logic [4:0]  P_AGC_ROI1        = 5'h02;
	localparam logic [4:0]  P_AGC_ROI2        = 5'h03;
	localparam logic [4:0]  P_AGC_ROI3        = 5'h04;
	localparam logic [4:0]  P_CLIP_HIGH       = 5'h05;
	localparam logic [4:0]  P_CLIP_LOW        = 5'h06;
	localparam logic [4:0]  P_DAMPING         = 5'h07;
	localparam logic [4:0]  P_TELEM_EN        = 5'h08;
	localparam logic [4:0]  P_TELEM_LOC       = 5'h09;
	localparam logic [4:0]  P_FFC_AVG         = 5'h0A;
	localparam logic [4:0]  P_FFC_MODE        = 5'h0B;
	localparam logic [4:0]  P_FFC_PER_LO      = 5'h0C;
	localparam logic [4:0]  P_FFC_PER_HI      = 5'h0D;
	localparam logic [4:0]  P_FFC_DELTA       = 5'h0E;
	localparam logic [4:0]  P_GAIN_MODE       = 5'h0F;
	localparam logic [4:0]  P_GSW_P_HL        = 5'h10;
	localparam logic [4:0]  P_GSW_P_LH        = 5'h11;
	localparam logic [4:0]  P_GSW_C_HL        = 5'h12;
	localparam logic [4:0]  P_GSW_C_LH        = 5'h13;
	localparam logic [4:0]  P_GSW_T_HL        = 5'h14;
	localparam logic [4:0]  P_GSW_T_LH        = 5'h15;
	localparam logic [4:0]  P_VID_FORMAT      = 5'h16;
	localparam logic [4:0]  P_COLOR_LUT       = 5'h17;
	localparam logic [4:0]  P_GPIO_MODE       = 5'h18;
	localparam logic [4:0]  P_VSYNC_DELAY     = 5'h19;
	localparam logic [4:0]  P_RADIOMETRY      = 5'h1A;
	localparam logic [4:0]  P_TLIN_EN         = 5'h1B;
	localparam logic [4:0]  P_TLIN_RES        = 5'h1C;
	localparam logic [4:0]  P_SPOT_ROI01      = 5'h1D;
	localparam logic [4:0]  P_SPOT_ROI23      = 5'h1E;
	localparam logic [4:0]  P_FLUX_SEL        = 5'h1F;

	// Power-on values
	localparam logic [15:0] PON_DISABLED      = 16'h0000;
	localparam logic [15:0] PON_ENABLED       = 16'h0001;
	localparam logic [15:0] PON_ROI_X_END     = 16'h004F;
	localparam logic [15:0] PON_ROI_Y_END     = 16'h003B;
	localparam logic [15:0] PON_CLIP_HIGH     = 16'h12C0;
	localparam logic [15:0] PON_CLIP_LOW      = 16'h0200;
	localparam logic [15:0] PON_DAMPING       = 16'h0040;
	localparam logic [15:0] PON_TELEM_FOOTER  = 16'h0001;
	localparam logic [15:0] PON_FFC_AVG       = 16'h0008;
	localparam logic [15:0] PON_FFC_AUTO      = 16'h0001;
	localparam logic [15:0] PON_FFC_PER_LO    = 16'hBF20;
	localparam logic [15:0] PON_FFC_PER_HI    = 16'h0002;
	localparam logic [15:0] PON_FFC_DELTA     = 16'h0096;
	localparam logic [15:0] PON_GAIN_HIGH     = 16'h0000;
	localparam logic [15:0] PON_GSW_P_HL      = 16'h0019;
	localparam logic [15:0] PON_GSW_P_LH      = 16'h005A;
	localparam logic [15:0] PON_GSW_C_HL      = 16'h0073;
	localparam logic [15:0] PON_GSW_C_LH      = 16'h0055;
	localparam logic [15:0] PON_GSW_T_HL      = 16'h0184;
	localparam logic [15:0] PON_GSW_T_LH      = 16'h0166;
	localparam logic [15:0] PON_FOURTEEN_BIT_RAW_FORMAT         = 16'h0000;
	localparam logic [15:0] PON_LUT_FUSION    = 16'h0001;
	localparam logic [15:0] PON_VSYNC_DELAY   = 16'h0000;
	localparam logic [15:0] PON_TLIN_RES_001  = 16'h0001;
	localparam logic [15:0] PON_SPOT_ROI01    = 16'h1E1D;
	localparam logic [15:0] PON_SPOT_ROI23    = 16'h2827;
	localparam logic [15:0] PON_FLUX_SEL      = 16'h0000;
	localparam logic [15:0] FLUX_EVEN         = 16'h2000;
	localparam logic [15:0] FLUX_ODD          = 16'h734B;
	localparam int          FLUX_N            = 6;

	// Telemetry word locations (row select in bits 9:8, word in 7:0)
	localparam logic [9:0]  TEL_A38           = 10'h026;
	localparam logic [9:0]  TEL_A39           = 10'h027;
	localparam logic [9:0]  TEL_A42           = 10'h02A;
	localparam logic [9:0]  TEL_A74           = 10'h04A;
	localparam logic [9:0]  TEL_B5            = 10'h105;
	localparam logic [9:0]  TEL_C48           = 10'h230;
	localparam logic [9:0]  TEL_C49           = 10'h231;
	localparam logic [9:0]  TEL_C50           = 10'h232;

	typedef struct packed {
		logic        valid;
		logic [1:0]  kind;
		logic [4:0]  index;
		logic [15:0] data;
	} cmd_report_t;

	typedef struct packed {
		logic [9:0]  loc;
		logic [15:0] data;
	} telem_word_t;

	typedef logic [15:0] pon_table_t [PARAM_N];

	function automatic logic [15:0] pon_value(input logic [4:0] idx);
		case (idx)
			P_AGC_ROI2:   pon_value = PON_ROI_X_END;
			P_AGC_ROI3:   pon_value = PON_ROI_Y_END;
			P_CLIP_HIGH:  pon_value = PON_CLIP_HIGH;
			P_CLIP_LOW:   pon_value = PON_CLIP_LOW;
			P_DAMPING:    pon_value = PON_DAMPING;
			P_TELEM_LOC:  pon_value = PON_TELEM_FOOTER;
			P_FFC_AVG:    pon_value = PON_FFC_AVG;
			P_FFC_MODE:   pon_value = PON_FFC_AUTO;
			P_FFC_PER_LO: pon_value = PON_FFC_PER_LO;
			P_FFC_PER_HI: pon_value = PON_FFC_PER_HI;
			P_FFC_DELTA:  pon_value = PON_FFC_DELTA;
			P_GAIN_MODE:  pon_value = PON_GAIN_HIGH;
			P_GSW_P_HL:   pon_value = PON_GSW_P_HL;
			P_GSW_P_LH:   pon_value = PON_GSW_P_LH;
			P_GSW_C_HL:   pon_value = PON_GSW_C_HL;
			P_GSW_C_LH:   pon_value = PON_GSW_C_LH;
			P_GSW_T_HL:   pon_value = PON_GSW_T_HL;
			P_GSW_T_LH:   pon_value = PON_GSW_T_LH;
			P_VID_FORMAT: pon_value = PON_FOURTEEN_BIT_RAW_FORMAT;
			P_COLOR_LUT:  pon_value = PON_LUT_FUSION;
			P_VSYNC_DELAY: pon_value = PON_VSYNC_DELAY;
			P_RADIOMETRY: pon_value = PON_ENABLED;
			P_TLIN_EN:    pon_value = PON_ENABLED;
			P_TLIN_RES:   pon_value = PON_TLIN_RES_001;
			P_SPOT_ROI01: pon_value = PON_SPOT_ROI01;
			P_SPOT_ROI23: pon_value = PON_SPOT_ROI23;
			default:      pon_value = PON_DISABLED;
		endcase
	endfunction : pon_value

endpackage : ccp_pkg

// ---- verilog/sync_filter.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sync_filter
	import ccp_pkg::*;
(
	input  wire logic i_clk,
	input  wire logic i_nrst,
	input  wire logic i_pin,
	output var  logic o_level
);
	logic [SYNC_STAGES-1:0] stage;
	logic                   next_level;

	always_comb begin
		next_level = o_level;
		// Stage 0 only feeds stage 1; the filter looks at stages 1 and 2
		if (stage[1] == stage[2]) begin
			next_level = stage[2];
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			// Idle-high reset: a low reset value would fake an edge on release
			stage   <= '1;
			o_level <= 1'b1;
		end else begin
			stage   <= {stage[SYNC_STAGES-2:0], i_pin};
			o_level <= next_level;
		end
	end

	if (SYNC_STAGES != 3) begin : g_stage_check
		$error("sync_filter needs three stages");
	end
endmodule : sync_filter
`default_nettype wire

// ---- verilog/command_control_port.sv ----
// Two-wire command and control slave with parameter store and user defaults
`timescale 1ns/100ps
`default_nettype none
module command_control_port
	import ccp_pkg::*;
(
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	input  wire logic         i_scl,
	input  wire logic         i_sda,
	input  wire logic         i_otp_programming_supply,
	input  wire logic         i_otp_valid,
	input  wire logic [511:0] i_otp_image,
	input  wire logic [15:0]  i_spot_value,
	output logic              o_sda_oe,
	output logic              o_sda_out,
	output logic              o_otp_write,
	output logic [511:0]      o_otp_image,
	output logic              o_otp_write_refused,
	output cmd_report_t       o_cmd,
	output telem_word_t       o_telem,
	output logic [15:0]       o_flux [FLUX_N],
	output logic              o_radiometry,
	output logic              o_tlinear,
	output logic              o_telem_en
);
	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_ADDR  = 6'b000010,
		S_ACK   = 6'b000100,
		S_RX    = 6'b001000,
		S_TX    = 6'b010000,
		S_WAIT  = 6'b100000
	} state_t;

	// ----------------------------------------------------------------
	// Pin sampling
	// ----------------------------------------------------------------
	logic scl;
	logic sda;
	logic scl_d;
	logic sda_d;

	sync_filter u_scl (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_scl),
		.o_level(scl));
	sync_filter u_sda (.i_clk(i_clk), .i_nrst(i_nrst), .i_pin(i_sda),
		.o_level(sda));

	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = scl & scl_d & sda_d & ~sda;
	wire stop_c   = scl & scl_d & ~sda_d & sda;

	// ----------------------------------------------------------------
	// Bus state
	// ----------------------------------------------------------------
	state_t      state;
	state_t      next_state;
	logic [3:0]  bitcnt;
	logic [3:0]  next_bitcnt;
	logic [7:0]  shreg;
	logic [7:0]  next_shreg;
	logic        rd;
	logic        next_rd;
	logic        odd;
	logic        next_odd;
	logic [15:0] word;
	logic [15:0] next_word;
	logic [1:0]  nwords;
	logic [1:0]  next_nwords;
	logic        word_done;
	logic [4:0]  ptr;
	logic [4:0]  next_ptr;
	logic [1:0]  kind;
	logic [1:0]  next_kind;
	logic        sda_oe;
	logic        next_sda_oe;
	logic [15:0] params [PARAM_N];
	logic [15:0] next_params [PARAM_N];
	logic        otp_write;
	logic        next_otp_write;
	logic        refused;
	logic        next_refused;
	cmd_report_t next_cmd;
	logic        loaded;
	logic        next_loaded;

	always_comb begin
		next_state     = state;
		next_bitcnt    = bitcnt;
		next_shreg     = shreg;
		next_rd        = rd;
		next_odd       = odd;
		next_word      = word;
		next_nwords    = nwords;
		next_ptr       = ptr;
		next_kind      = kind;
		next_sda_oe    = sda_oe;
		next_params    = params;
		next_otp_write = 1'b0;
		next_refused   = 1'b0;
		next_loaded    = 1'b1;
		next_cmd       = '0;
		word_done      = 1'b0;
		// Stored user defaults replace the factory values once after reset
		if (!loaded && i_otp_valid) begin
			for (int k = 0; k < PARAM_N; k++) begin
				next_params[k] = i_otp_image[k*WORD_W +: WORD_W];
			end
		end
		if (start_c) begin
			next_state  = S_ADDR;
			next_bitcnt = '0;
			next_odd    = 1'b0;
			next_nwords = '0;
			next_sda_oe = 1'b0;
		end else if (stop_c) begin
			next_state  = S_IDLE;
			next_sda_oe = 1'b0;
		end else begin
			case (state)
				S_IDLE: begin
				end
				S_ADDR, S_RX: begin
					if (scl_rise) begin
						next_shreg  = {shreg[6:0], sda};
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall && bitcnt == 4'h8) begin
						next_bitcnt = '0;
						if (state == S_ADDR) begin
							if (shreg[7:1] == SLAVE_ADDR) begin
								next_rd     = shreg[0];
								next_sda_oe = 1'b1;
								next_state  = S_ACK;
								next_word   = params[ptr];
							end else begin
								next_state = S_WAIT;
							end
						end else begin
							next_sda_oe = 1'b1;
							next_state  = S_ACK;
							// Bytes pair high then low into one word
							next_odd    = ~odd;
							next_word   = {word[7:0], shreg};
							word_done   = odd;
						end
					end
				end
				S_ACK: begin
					if (scl_fall) begin
						next_sda_oe = rd ? ~word[{~odd, 3'h7}] : 1'b0;
						next_state  = rd ? S_TX : S_RX;
						next_bitcnt = '0;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						next_bitcnt = bitcnt + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt == 4'h8) begin
							next_sda_oe = 1'b0;
							next_state  = S_WAIT;
							next_odd    = ~odd;
							next_word   = odd ? params[ptr + 5'h1] : word;
							if (odd) next_ptr = ptr + 5'h1;
						end else begin
							next_sda_oe = ~word[{~odd, 3'h7 - bitcnt[2:0]}];
						end
					end
				end
				S_WAIT: begin
					// Host acknowledge of a read byte: continue only on ACK low
					if (rd && scl_rise) begin
						next_state = sda ? S_WAIT : S_ACK;
					end
				end
				default: next_state = S_IDLE;
			endcase
		end
		if (word_done) begin
			next_nwords = (nwords == 2'h3) ? nwords : nwords + 2'h1;
			if (nwords == 2'h0) begin
				next_kind = next_word[1:0];
				next_ptr  = next_word[CMD_IDX_LSB +: IDX_W];
				next_cmd  = '{next_word[1:0] != CMD_BAD, next_word[1:0],
					next_word[CMD_IDX_LSB +: IDX_W], 16'h0};
				if (next_word[1:0] == CMD_RUN) begin
					if (next_word[CMD_IDX_LSB +: IDX_W] == RUN_SAVE_DEFAULTS) begin
						next_otp_write = i_otp_programming_supply;
						next_refused   = ~i_otp_programming_supply;
					end else if (next_word[CMD_IDX_LSB +: IDX_W] == RUN_LOAD_DEFAULTS) begin
						for (int k = 0; k < PARAM_N; k++) begin
							next_params[k] = pon_value(5'(k));
						end
					end
				end
			end else if (kind == CMD_SET) begin
				next_params[ptr] = next_word;
				next_cmd = '{1'b1, CMD_SET, ptr, next_word};
				next_ptr = ptr + 5'h1;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			scl_d     <= 1'b1;
			sda_d     <= 1'b1;
			state     <= S_IDLE;
			bitcnt    <= '0;
			shreg     <= '0;
			rd        <= 1'b0;
			odd       <= 1'b0;
			word      <= '0;
			nwords    <= '0;
			ptr       <= '0;
			kind      <= CMD_GET;
			sda_oe    <= 1'b0;
			otp_write <= 1'b0;
			refused   <= 1'b0;
			loaded    <= 1'b0;
			o_cmd     <= '0;
			for (int k = 0; k < PARAM_N; k++) begin
				params[k] <= pon_value(5'(k));
			end
		end else begin
			scl_d     <= scl;
			sda_d     <= sda;
			state     <= next_state;
			bitcnt    <= next_bitcnt;
			shreg     <= next_shreg;
			rd        <= next_rd;
			odd       <= next_odd;
			word      <= next_word;
			nwords    <= next_nwords;
			ptr       <= next_ptr;
			kind      <= next_kind;
			sda_oe    <= next_sda_oe;
			otp_write <= next_otp_write;
			refused   <= next_refused;
			loaded    <= next_loaded;
			o_cmd     <= next_cmd;
			params    <= next_params;
		end
	end

	// ----------------------------------------------------------------
	// Outputs and telemetry mirror
	// ----------------------------------------------------------------
	logic [2:0]  tel_sel;
	telem_word_t next_tel;

	always_comb begin
		case (tel_sel)
			3'h0:    next_tel = '{TEL_A38, params[P_CLIP_HIGH]};
			3'h1:    next_tel = '{TEL_A39, params[P_CLIP_LOW]};
			3'h2:    next_tel = '{TEL_A42, params[P_DAMPING]};
			3'h3:    next_tel = '{TEL_A74, params[P_FFC_AVG]};
			3'h4:    next_tel = '{TEL_B5,  params[P_GAIN_MODE]};
			3'h5:    next_tel = '{TEL_C48, params[P_TLIN_EN]};
			3'h6:    next_tel = '{TEL_C49, params[P_TLIN_RES]};
			default: next_tel = '{TEL_C50, i_spot_value};
		endcase
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tel_sel             <= '0;
			o_telem             <= '0;
			o_sda_oe            <= 1'b0;
			o_sda_out           <= 1'b0;
			o_otp_write         <= 1'b0;
			o_otp_image         <= '0;
			o_otp_write_refused <= 1'b0;
			o_radiometry        <= 1'b1;
			o_tlinear           <= 1'b1;
			o_telem_en          <= 1'b0;
			for (int k = 0; k < FLUX_N; k++) begin
				o_flux[k] <= k[0] ? FLUX_ODD : FLUX_EVEN;
			end
		end else begin
			tel_sel             <= tel_sel + 3'h1;
			o_telem             <= next_tel;
			o_sda_oe            <= sda_oe;
			o_sda_out           <= 1'b0;
			o_otp_write         <= otp_write;
			o_otp_write_refused <= refused;
			o_radiometry        <= params[P_RADIOMETRY][0];
			o_tlinear           <= params[P_TLIN_EN][0];
			o_telem_en          <= params[P_TELEM_EN][0];
			for (int k = 0; k < PARAM_N; k++) begin
				o_otp_image[k*WORD_W +: WORD_W] <= params[k];
			end
			for (int k = 0; k < FLUX_N; k++) begin
				o_flux[k] <= k[0] ? FLUX_ODD : FLUX_EVEN;
			end
		end
	end
endmodule : command_control_port
`default_nettype wire

// ---- tb/ccp_props.sv ----
// Checker: pin-level properties of the command and control port
`timescale 1ns/100ps
`default_nettype none
module ccp_props
	import ccp_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_nrst,
	input wire logic        i_scl,
	input wire logic        i_otp_programming_supply,
	input wire logic        o_sda_oe,
	input wire logic        o_sda_out,
	input wire logic        o_otp_write,
	input wire logic        o_otp_write_refused,
	input wire cmd_report_t o_cmd,
	input wire logic [15:0] o_flux [FLUX_N],
	input wire logic        o_radiometry,
	input wire logic        o_tlinear,
	input wire logic        o_telem_en
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);

	a_sda_open_drain: assert property (o_sda_out == 1'b0)
		else $error("sda output level not low");
	a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda drive changed while scl high");
	a_reset_levels: assert property ($rose(i_nrst) |-> o_radiometry && o_tlinear && !o_telem_en && !o_sda_oe)
		else $error("wrong levels out of reset");
	a_refuse_no_supply: assert property (o_otp_write_refused |-> !$past(i_otp_programming_supply, 2))
		else $error("save refused with supply present");
	a_write_supply: assert property (o_otp_write |-> $past(i_otp_programming_supply, 2))
		else $error("otp written without supply");
	a_write_single: assert property (o_otp_write |=> !o_otp_write)
		else $error("otp write pulse too long");
	a_otp_exclusive: assert property (!(o_otp_write && o_otp_write_refused))
		else $error("otp write and refusal together");
	a_cmd_single: assert property (o_cmd.valid |=> !o_cmd.valid)
		else $error("command report longer than one cycle");
	a_cmd_kind: assert property (o_cmd.valid |-> o_cmd.kind != CMD_BAD)
		else $error("command of unknown kind reported");
	a_flux_list: assert property (o_flux[0] == 16'h2000 && o_flux[1] == 16'h734B && o_flux[2] == 16'h2000 && o_flux[3] == 16'h734B && o_flux[4] == 16'h2000 && o_flux[5] == 16'h734B)
		else $error("flux list value wrong");
endmodule : ccp_props

bind command_control_port ccp_props u_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl),
	.i_otp_programming_supply(i_otp_programming_supply), .o_sda_oe(o_sda_oe),
	.o_sda_out(o_sda_out), .o_otp_write(o_otp_write), .o_otp_write_refused(o_otp_write_refused),
	.o_cmd(o_cmd), .o_flux(o_flux), .o_radiometry(o_radiometry), .o_tlinear(o_tlinear),
	.o_telem_en(o_telem_en));
`default_nettype wire

// ---- tb/bus_host_model.sv ----
// Host model: two-wire bus master driving scl and pulling sda low
`timescale 1ns/100ps
`default_nettype none
module bus_host_model #(
	parameter int HALF = 12
) (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output var  logic o_scl,
	output var  logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
	endtask : tick
	// Data moves HALF / 2 clocks (a fifth of a bit) after scl falls so the filtered pins never see it as start or stop
	task automatic clk_bit(input logic low, output logic seen);
		o_sda_low <= low;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		seen = i_sda;
		o_scl <= 1'b0;
		tick(HALF / 2);
	endtask : clk_bit
	task automatic start_cond;
		o_sda_low <= 1'b0;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b0;
		tick(HALF / 2);
	endtask : start_cond
	task automatic stop_cond;
		o_sda_low <= 1'b1;
		tick(HALF);
		o_scl <= 1'b1;
		tick(HALF);
		o_sda_low <= 1'b0;
		tick(HALF);
	endtask : stop_cond
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(!b[i], s);
		clk_bit(1'b0, s);
		ack = !s;
	endtask : put_byte
	task automatic get_byte(output logic [7:0] b, input logic ack_low);
		logic s;
		for (int i = 7; i >= 0; i--) clk_bit(1'b0, b[i]);
		clk_bit(ack_low, s);
	endtask : get_byte
endmodule : bus_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// Testbench: command and control port driven through the host model
`timescale 1ns/100ps
`default_nettype none
module tb
	import ccp_pkg::*;
;
	localparam logic [15:0] PON_EXP [32] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h004F, 16'h003B, 16'h12C0, 16'h0200, 16'h0040,
		16'h0000, PON_TELEM_FOOTER, 16'h0008, PON_FFC_AUTO, 16'hBF20, 16'h0002, 16'h0096,
		PON_GAIN_HIGH, 16'h0019, 16'h005A, 16'h0073, 16'h0055, 16'h0184, 16'h0166, PON_FOURTEEN_BIT_RAW_FORMAT,
		PON_LUT_FUSION, 16'h0000, 16'h0000, 16'h0001, 16'h0001, PON_TLIN_RES_001, 16'h1E1D,
		16'h2827, 16'h0000};
	logic         i_clk = 1'b0;
	logic         i_nrst = 1'b0;
	logic         supply = 1'b0;
	logic         otp_valid = 1'b0;
	logic [511:0] img_in = '0;
	logic [15:0]  spot = 16'h0000;
	logic         scl;
	logic         host_low;
	logic         sda_oe;
	logic         otp_wr;
	logic         otp_ref;
	logic [511:0] img_out;
	logic [511:0] wr_img;
	cmd_report_t  cmd;
	cmd_report_t  exp_n;
	cmd_report_t  notes [$];
	telem_word_t  telem;
	logic [15:0]  flux [FLUX_N];
	logic         radio;
	logic         tlin;
	logic         tel_en;
	int           n_mismatch = 0;
	int           total_checks = 0;
	int           cyc = 0;
	int           n_ref = 0;
	int           n_wr = 0;
	wire          sda_line = !(host_low || sda_oe);

	always #4 i_clk = ~i_clk;

	command_control_port dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_line),
		.i_otp_programming_supply(supply), .i_otp_valid(otp_valid), .i_otp_image(img_in),
		.i_spot_value(spot), .o_sda_oe(sda_oe), .o_sda_out(), .o_otp_write(otp_wr),
		.o_otp_image(img_out), .o_otp_write_refused(otp_ref), .o_cmd(cmd), .o_telem(telem),
		.o_flux(flux), .o_radiometry(radio), .o_tlinear(tlin), .o_telem_en(tel_en));
	bus_host_model #(.HALF(12)) host (.i_clk(i_clk), .i_sda(sda_line), .o_scl(scl),
		.o_sda_low(host_low));

	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	task automatic send_cmd(input logic [6:0] addr, input logic [1:0] kind, input logic [4:0] idx,
		output logic ack);
		logic        a;
		logic [15:0] w;
		w = {9'h000, idx, kind};
		@(posedge i_clk);
		host.start_cond();
		host.put_byte({addr, 1'b0}, ack);
		if (ack) begin
			host.put_byte(w[15:8], a);
			host.put_byte(w[7:0], a);
		end
	endtask : send_cmd
	task automatic note(input logic [1:0] kind, input logic [4:0] idx,
		input logic [15:0] data = 16'h0000);
		notes.push_back(cmd_report_t'{1'b1, kind, idx, data});
	endtask : note
	task automatic set_param(input logic [4:0] idx, input logic [15:0] val);
		logic a;
		note(CMD_SET, idx);
		note(CMD_SET, idx, val);
		send_cmd(SLAVE_ADDR, CMD_SET, idx, a);
		host.put_byte(val[15:8], a);
		host.put_byte(val[7:0], a);
		host.stop_cond();
	endtask : set_param
	task automatic get_param(input logic [4:0] idx, output logic [15:0] val);
		logic a;
		note(CMD_GET, idx);
		send_cmd(SLAVE_ADDR, CMD_GET, idx, a);
		host.start_cond();
		host.put_byte({SLAVE_ADDR, 1'b1}, a);
		host.get_byte(val[15:8], 1'b1);
		host.get_byte(val[7:0], 1'b0);
		host.stop_cond();
	endtask : get_param
	task automatic run_cmd(input logic [4:0] code);
		logic a;
		note(CMD_RUN, code);
		send_cmd(SLAVE_ADDR, CMD_RUN, code, a);
		host.stop_cond();
		repeat (8) @(negedge i_clk);
	endtask : run_cmd
	task automatic telem_at(input logic [9:0] loc, input logic [15:0] exp);
		for (int k = 0; k < 64 && telem.loc !== loc; k++) @(negedge i_clk);
		chk("telemetry location", {6'h00, loc}, {6'h00, telem.loc});
		chk("telemetry word", exp, telem.data);
	endtask : telem_at

	// ----------------------------------------
	// Result watcher and hang limit
	// ----------------------------------------
	always @(negedge i_clk) begin
		cyc <= cyc + 1;
		if (otp_ref === 1'b1) n_ref++;
		if (otp_wr === 1'b1) begin
			n_wr++;
			wr_img = img_out;
		end
		if (cmd.valid === 1'b1) begin
			if (notes.size() == 0) chk("unexpected command report", 16'h0000, 16'hFFFF);
			else begin
				exp_n = notes.pop_front();
				chk("command kind and index", {9'h000, exp_n.index, exp_n.kind}, {9'h000, cmd.index, cmd.kind});
				chk("command data", exp_n.data, cmd.data);
			end
		end
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end

	initial begin
		logic [15:0]  v;
		logic [15:0]  r;
		logic [511:0] img;
		logic         ack;
		int           seed;
		seed = $urandom(32'hC5A23BE5);
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (10) @(negedge i_clk);
		for (int i = 0; i < 32; i++) chk("power-on parameter", PON_EXP[i], img_out[16*i +: 16]);
		for (int i = 0; i < FLUX_N; i++) chk("flux entry", i[0] ? 16'h734B : 16'h2000, flux[i]);
		chk("radiometry, linear, telemetry", 16'h0006, {13'h0000, radio, tlin, tel_en});
		v = 16'($urandom());
		@(posedge i_clk);
		spot <= 16'($urandom());
		set_param(P_CLIP_HIGH, v);
		repeat (8) @(negedge i_clk);
		chk("clip high after set", v, img_out[16*P_CLIP_HIGH +: 16]);
		telem_at(TEL_A38, v);
		telem_at(TEL_B5, PON_GAIN_HIGH);
		telem_at(TEL_C50, spot);
		get_param(P_CLIP_HIGH, r);
		chk("clip high read back", v, r);
		get_param(P_DAMPING, r);
		chk("dampening read back", 16'h0040, r);
		send_cmd(SLAVE_ADDR ^ 7'h01, CMD_SET, P_CLIP_LOW, ack);
		host.stop_cond();
		chk("ack to foreign address", 16'h0000, {15'h0000, ack});
		note(CMD_SET, P_FFC_DELTA);
		send_cmd(SLAVE_ADDR, CMD_SET, P_FFC_DELTA, ack);
		host.put_byte(8'hA5, ack);
		host.stop_cond();
		repeat (8) @(negedge i_clk);
		chk("delta after odd byte", 16'h0096, img_out[16*P_FFC_DELTA +: 16]);
		// A command of the unused fourth kind is neither reported nor applied
		send_cmd(SLAVE_ADDR, CMD_BAD, P_CLIP_LOW, ack);
		host.put_byte(8'h12, ack);
		host.put_byte(8'h34, ack);
		host.stop_cond();
		repeat (8) @(negedge i_clk);
		chk("clip low after bad kind", 16'h0200, img_out[16*P_CLIP_LOW +: 16]);
		run_cmd(RUN_SAVE_DEFAULTS);
		chk("refusals", 16'h0001, 16'(n_ref));
		chk("otp writes while refused", 16'h0000, 16'(n_wr));
		@(posedge i_clk);
		supply <= 1'b1;
		run_cmd(RUN_SAVE_DEFAULTS);
		chk("otp writes", 16'h0001, 16'(n_wr));
		chk("stored clip high", v, wr_img[16*P_CLIP_HIGH +: 16]);
		chk("stored period low", 16'hBF20, wr_img[16*P_FFC_PER_LO +: 16]);
		@(posedge i_clk);
		supply <= 1'b0;
		run_cmd(RUN_LOAD_DEFAULTS);
		chk("clip high restored", 16'h12C0, img_out[16*P_CLIP_HIGH +: 16]);
		// Power up again with saved defaults present: no host set-up may be needed
		v = 16'($urandom());
		for (int i = 0; i < 32; i++) img[16*i +: 16] = PON_EXP[i];
		img[16*P_CLIP_HIGH +: 16] = v;
		@(posedge i_clk);
		img_in <= img;
		otp_valid <= 1'b1;
		i_nrst <= 1'b0;
		repeat (5) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (10) @(negedge i_clk);
		chk("clip high from otp", v, img_out[16*P_CLIP_HIGH +: 16]);
		chk("period high from otp", 16'h0002, img_out[16*P_FFC_PER_HI +: 16]);
		chk("pending command notes", 16'h0000, 16'(notes.size()));
		wrap_up();
	end
endmodule : tb
`default_nettype wire
